/* common/usb_wrap_pkg.sv */
// package: register map, field layout and reset values of the usb wrapper
package usb_wrap_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // byte offsets (word aligned)
    localparam logic [7:0] RNDIS_EN_OFF = 8'h00;
    localparam logic [7:0] AUTO_REQ_OFF = 8'h04;
    localparam logic [7:0] RAW_SRC_OFF = 8'h08;
    localparam logic [7:0] SRC_SET_OFF = 8'h0C;
    localparam logic [7:0] SRC_CLR_OFF = 8'h10;
    localparam logic [7:0] MASK_OFF = 8'h14;
    localparam logic [7:0] MASKED_OFF = 8'h18;
    // endpoint enable field positions
    localparam int RNDIS_RX_LSB = 16;
    localparam int RNDIS_TX_LSB = 0;
    localparam int NUM_EP = 4;
    localparam int AUTO_REQ_W = 8;
    // interrupt source field layout
    localparam int GEN_LSB = 16;
    localparam int GEN_W = 9;
    localparam int RXI_LSB = 8;
    localparam int RXI_W = 5;
    localparam int TXI_LSB = 0;
    localparam int TXI_W = 5;
    localparam logic [31:0] SRC_VALID = 32'h01FF_1F1F;
    localparam logic [31:0] RNDIS_VALID = 32'h000F_000F;
    // reset values
    localparam logic [31:0] RNDIS_RST = 32'h0000_0000;
    localparam logic [7:0] AUTO_REQ_RST = 8'h00;
    localparam logic [31:0] SRC_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    // automatic in-request modes
    localparam logic [1:0] AREQ_NONE = 2'h0;
    localparam logic [1:0] AREQ_BUT_EOP = 2'h1;
    localparam logic [1:0] AREQ_RSVD = 2'h2;
    localparam logic [1:0] AREQ_ALWAYS = 2'h3;
endpackage : usb_wrap_pkg

/* design/usb_wrap_regs.sv */
// usb wrapper registers: rndis enables, auto request, interrupt sources
//////////////////////////////////////////////////////////////////////////
// Operation
// [R1] bits 19..16 enable rndis for receive endpoints 4..1, reset zero
// [R2] bits 3..0 enable rndis for transmit endpoints 4..1, reset zero
// [R3] auto request holds 2-bit field per receive endpoint, bits 31-8 zero
// [R4] field 0 none, 1 all but last packet, 3 always, 2 reserved
// [R5] raw source read-only, reset zero, core general sources in 24-16
// [R6] receive endpoint sources in bits 12-8, bits 15-13 read zero
// [R7] transmit endpoint sources in bits 4-0, 7-5 and 31-25 zero
// [R8] set register ones in 24-16 raise general source bits
// [R9] set register ones in 12-8 raise receive endpoint source bits
// [R10] set register ones in 4-0 raise transmit endpoint source bits
// [R11] software-raised sources behave exactly like core-raised ones
// [R12] clear register ones in 24-16 drop general source bits
// [R13] clear register ones in 12-8 drop receive endpoint source bits
// [R14] clear register ones in 4-0 drop transmit endpoint source bits
// [R15] software acknowledges each serviced source via the clear register
// [R16] masked status equals raw source anded with mask, same layout
// [R17] zero writes to set or clear do nothing; they read zero
// [R18] core event in same cycle as clear leaves the bit set
// [R19] reserved bits read zero and writes to them are ignored
//
// Our own choices: the address-and-strobe port and the register addresses.
module usb_wrap_regs
    import usb_wrap_pkg::*;
#(
    parameter int NUM_EP_P = usb_wrap_pkg::NUM_EP
)
(
    input wire logic core_clk_i,                 // module clock
    input wire logic resetn_i,                   // sync reset, active low
    input wire logic [usb_wrap_pkg::ADDR_W-1:0] addr_i, // byte address
    input wire logic [usb_wrap_pkg::DATA_W-1:0] wdata_i, // write data
    input wire logic wr_i,                       // write strobe
    input wire logic rd_i,                       // read strobe
    output logic [usb_wrap_pkg::DATA_W-1:0] rdata_o, // read data
    input wire logic [usb_wrap_pkg::GEN_W-1:0] core_gen_evt_i, // core events
    input wire logic [usb_wrap_pkg::RXI_W-1:0] core_rx_evt_i, // rx ep events
    input wire logic [usb_wrap_pkg::TXI_W-1:0] core_tx_evt_i, // tx ep events
    output logic [3:0] rx_rndis_on_o,            // rx ep 4..1 rndis enable
    output logic [3:0] tx_rndis_on_o,            // tx ep 4..1 rndis enable
    output logic [7:0] auto_in_request_o,        // per-ep auto request mode
    output logic irq_o                           // level interrupt
);
    import usb_wrap_pkg::*;

    //////////////////////////////////////////////////////////////////////
    logic [31:0] rndis_endpoint_enable_reg;
    logic [7:0] rx_auto_request_config_reg;
    logic [31:0] irq_raw_source_reg;
    logic [31:0] irq_raw_source_next;
    logic [31:0] irq_mask_reg;
    logic [31:0] irq_masked_status;
    logic [31:0] core_evt;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic [31:0] rdata_next;
    logic wr_set;
    logic wr_clr;

    // [R17] set and clear only act on a write strobe
    assign wr_set = wr_i && (addr_i == SRC_SET_OFF);
    assign wr_clr = wr_i && (addr_i == SRC_CLR_OFF);

    // [R5] core events placed in the source layout
    always_comb
    begin
        core_evt = 32'h0000_0000;
        core_evt[GEN_LSB +: GEN_W] = core_gen_evt_i;
        // [R6] receive endpoint sources
        core_evt[RXI_LSB +: RXI_W] = core_rx_evt_i;
        // [R7] transmit endpoint sources
        core_evt[TXI_LSB +: TXI_W] = core_tx_evt_i;
    end

    // [R8] set register strobes, zero bits do nothing
    // [R9] receive endpoint set bits
    // [R10] transmit endpoint set bits
    assign sw_set = wr_set ? (wdata_i & SRC_VALID) : 32'h0000_0000;
    // [R12] clear register strobes, zero bits do nothing
    // [R13] receive endpoint clear bits
    // [R14] transmit endpoint clear bits
    assign sw_clr = wr_clr ? (wdata_i & SRC_VALID) : 32'h0000_0000;

    //////////////////////////////////////////////////////////////////////
    // [R18] set beats clear so a coincident event survives
    always_comb
    begin
        irq_raw_source_next = (irq_raw_source_reg & ~sw_clr)
                            | (core_evt & SRC_VALID) | sw_set;
    end

    // [R11] software and core sets share one path
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            irq_raw_source_reg <= SRC_RST;
        else
            irq_raw_source_reg <= irq_raw_source_next;
    end

    // [R1] rndis enable register, reserved bits dropped
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            rndis_endpoint_enable_reg <= RNDIS_RST;
        else if (wr_i && addr_i == RNDIS_EN_OFF)
            rndis_endpoint_enable_reg <= wdata_i & RNDIS_VALID;
    end

    // [R3] auto request register, upper bits never stored
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            rx_auto_request_config_reg <= AUTO_REQ_RST;
        else if (wr_i && addr_i == AUTO_REQ_OFF)
            rx_auto_request_config_reg <= wdata_i[AUTO_REQ_W-1:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            irq_mask_reg <= MASK_RST;
        else if (wr_i && addr_i == MASK_OFF)
            irq_mask_reg <= wdata_i & SRC_VALID;
    end

    // [R16] masked view of the raw sources
    assign irq_masked_status = irq_raw_source_reg & irq_mask_reg;

    //////////////////////////////////////////////////////////////////////
    // [R19] read decode, unmapped and write-only offsets read zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (addr_i == RNDIS_EN_OFF)
            rdata_next = rndis_endpoint_enable_reg;
        else if (addr_i == AUTO_REQ_OFF)
            rdata_next = {24'h00_0000, rx_auto_request_config_reg};
        else if (addr_i == RAW_SRC_OFF)
            rdata_next = irq_raw_source_reg;
        else if (addr_i == MASK_OFF)
            rdata_next = irq_mask_reg;
        else if (addr_i == MASKED_OFF)
            rdata_next = irq_masked_status;
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
            rdata_o <= 32'h0000_0000;
        else if (rd_i)
            rdata_o <= rdata_next;
        else
            rdata_o <= 32'h0000_0000;
    end

    // outputs registered; interrupt lags the masked status by one cycle
    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            rx_rndis_on_o <= 4'h0;
            tx_rndis_on_o <= 4'h0;
            auto_in_request_o <= 8'h00;
            irq_o <= 1'b0;
        end
        else
        begin
            // [R2] per-endpoint enables to the core
            rx_rndis_on_o <= rndis_endpoint_enable_reg[RNDIS_RX_LSB +: 4];
            tx_rndis_on_o <= rndis_endpoint_enable_reg[RNDIS_TX_LSB +: 4];
            // [R4] mode codes passed unchanged; the core decodes them
            auto_in_request_o <= rx_auto_request_config_reg;
            irq_o <= |irq_masked_status;
        end
    end

    //////////////////////////////////////////////////////////////////////
    sequence clr_write_s(int b);
        wr_clr && wdata_i[b];
    endsequence

    // [R1]
    chk_rndis_write_hold: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        wr_i && addr_i == RNDIS_EN_OFF |=> ##1
        rx_rndis_on_o == $past(wdata_i[19:16], 2))
        else $error("rx rndis enable not taken");
    // [R2]
    chk_tx_rndis_map: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        wr_i && addr_i == RNDIS_EN_OFF |=> ##1
        tx_rndis_on_o == $past(wdata_i[3:0], 2))
        else $error("tx rndis enable not taken");
    // [R3]
    chk_auto_req_read: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        rd_i && addr_i == AUTO_REQ_OFF |=> rdata_o[31:8] == 24'h00_0000)
        else $error("auto request upper bits nonzero");
    // [R8]
    chk_set_raises: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        wr_set |=> (irq_raw_source_reg & $past(wdata_i & SRC_VALID))
        == $past(wdata_i & SRC_VALID))
        else $error("set write did not raise source");
    // [R12]
    chk_clear_drops: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clr_write_s(16) && !core_gen_evt_i[0] |=> !irq_raw_source_reg[16])
        else $error("clear write did not drop source");
    // [R18]
    chk_event_beats_clr: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        clr_write_s(8) && core_rx_evt_i[0] |=> irq_raw_source_reg[8])
        else $error("event lost against clear");
    // [R16]
    chk_irq_masked: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        ##1 irq_o == |($past(irq_raw_source_reg & irq_mask_reg)))
        else $error("interrupt disagrees with masked status");
    // [R19]
    chk_reserved_zero: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        (irq_raw_source_reg & ~SRC_VALID) == 32'h0000_0000)
        else $error("reserved source bit set");
    // [R17]
    chk_wo_reads_zero: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        rd_i && (addr_i == SRC_SET_OFF || addr_i == SRC_CLR_OFF)
        |=> rdata_o == 32'h0000_0000)
        else $error("write-only register read nonzero");
endmodule : usb_wrap_regs

/* sim/tb_top.sv */
// self-checking bench for the usb wrapper register block
module tb_top
    import usb_wrap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [8:0] core_gen_evt_i = 9'h000;
    logic [4:0] core_rx_evt_i = 5'h00;
    logic [4:0] core_tx_evt_i = 5'h00;
    logic [31:0] rdata_o;
    logic [3:0] rx_rndis_on_o;
    logic [3:0] tx_rndis_on_o;
    logic [7:0] auto_in_request_o;
    logic irq_o;
    logic [31:0] exp_q[$];
    logic [31:0] evt_v = 32'h0;
    logic [31:0] v;
    logic rd_d = 1'b0;
    int bad_count = 0;
    int samples_checked = 0;
    int seed = 32'h4C88;
    int i;

    always #20 core_clk_i = ~core_clk_i;

    usb_wrap_regs usb_wrap_regs_inst (.core_clk_i(core_clk_i),
        .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .core_gen_evt_i(core_gen_evt_i), .core_rx_evt_i(core_rx_evt_i),
        .core_tx_evt_i(core_tx_evt_i), .rx_rndis_on_o(rx_rndis_on_o),
        .tx_rndis_on_o(tx_rndis_on_o),
        .auto_in_request_o(auto_in_request_o), .irq_o(irq_o));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // events ride along with every bus cycle so they never double-drive
    task automatic bus(input logic w, input logic r, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge core_clk_i);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
        core_gen_evt_i <= evt_v[24:16];
        core_rx_evt_i <= evt_v[12:8];
        core_tx_evt_i <= evt_v[4:0];
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0);
    endtask : idle

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////
    // read data stands only in the cycle after the strobe
    always @(posedge core_clk_i)
    begin
        if (rd_d)
            chk("rdata_o", exp_q.pop_front(), rdata_o);
        else if (resetn_i)
            chk("rdata_idle", 32'h0, rdata_o);
        rd_d <= rd_i;
    end

    initial
    begin
        repeat (3000) @(posedge core_clk_i);
        bad_count++;
        complete_run();
    end

    initial
    begin
        repeat (5) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        bus(1'b1, 1'b0, 8'h1C, 32'hFFFF_FFFF);
        for (i = 0; i < 8; i++)
            rd(8'(i * 4), 32'h0);
        v = $random(seed);
        bus(1'b1, 1'b0, RNDIS_EN_OFF, v);
        rd(RNDIS_EN_OFF, v & RNDIS_VALID);
        idle(3);
        chk("rndis_on", {24'h0, v[19:16], v[3:0]},
            {24'h0, rx_rndis_on_o, tx_rndis_on_o});
        for (i = 0; i < 4; i++)
        begin
            v = $random(seed);
            v[7:0] = 8'h55 * 8'(i);
            bus(1'b1, 1'b0, AUTO_REQ_OFF, v);
            rd(AUTO_REQ_OFF, {24'h0, v[7:0]});
            idle(3);
            chk("auto_req", {24'h0, v[7:0]}, {24'h0, auto_in_request_o});
        end
        for (i = 0; i < 2; i++)
        begin
            v = (i == 0) ? $random(seed) : ~SRC_VALID;
            bus(1'b1, 1'b0, MASK_OFF, v);
            bus(1'b1, 1'b0, SRC_SET_OFF, 32'hFFFF_FFFF);
            rd(MASK_OFF, v & SRC_VALID);
            rd(RAW_SRC_OFF, SRC_VALID);
            rd(MASKED_OFF, v & SRC_VALID);
            idle(3);
            chk("irq_o", {31'h0, |(v & SRC_VALID)}, {31'h0, irq_o});
        end
        bus(1'b1, 1'b0, SRC_CLR_OFF, 32'h0);
        rd(RAW_SRC_OFF, SRC_VALID);
        rd(SRC_SET_OFF, 32'h0);
        rd(SRC_CLR_OFF, 32'h0);
        v = $random(seed);
        bus(1'b1, 1'b0, SRC_CLR_OFF, v);
        rd(RAW_SRC_OFF, SRC_VALID & ~v);
        bus(1'b1, 1'b0, MASK_OFF, 32'hFFFF_FFFF);
        idle(3);
        chk("irq_o", {31'h0, |(SRC_VALID & ~v)}, {31'h0, irq_o});
        bus(1'b1, 1'b0, SRC_CLR_OFF, 32'hFFFF_FFFF);
        rd(RAW_SRC_OFF, 32'h0);
        idle(3);
        chk("irq_o", 32'h0, {31'h0, irq_o});
        v = $random(seed) & SRC_VALID;
        evt_v = v;
        idle(1);
        evt_v = 32'h0;
        rd(RAW_SRC_OFF, v);
        idle(3);
        chk("irq_o", {31'h0, |v}, {31'h0, irq_o});
        // core event on the same edge as a full clear must survive
        evt_v = 32'h0000_0001;
        bus(1'b1, 1'b0, SRC_CLR_OFF, 32'hFFFF_FFFF);
        evt_v = 32'h0;
        rd(RAW_SRC_OFF, 32'h0000_0001);
        idle(3);
        // reset in mid-run must return the raw source, rndis and auto request registers and every output to zero
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rd(RAW_SRC_OFF, 32'h0);
        rd(RNDIS_EN_OFF, 32'h0);
        rd(AUTO_REQ_OFF, 32'h0);
        idle(3);
        chk("out_rst", 32'h0, {15'h0, irq_o, auto_in_request_o,
            rx_rndis_on_o, tx_rndis_on_o});
        complete_run();
    end
endmodule : tb_top
